// >>> design/pmt_pkg.sv
// package: register map, field layout and shared types of the period timer
package pmt_pkg;

  // register offsets; some printed offsets are not multiples of four, so the
  // printed values are indices and byte address is four times the index
  localparam logic [7:0]  PMT_IDX_FLAGS   = 8'h0C;
  localparam logic [7:0]  PMT_IDX_COUNT   = 8'h11;
  localparam logic [7:0]  PMT_IDX_CONTROL = 8'h12;
  localparam logic [7:0]  PMT_IDX_ENABLES = 8'h8C;
  localparam logic [7:0]  PMT_IDX_PERIOD  = 8'h92;

  // field positions
  localparam int          PMT_PRE_LSB     = 0;
  localparam int          PMT_RUN_BIT     = 2;
  localparam int          PMT_POST_LSB    = 3;
  localparam int          PMT_MATCH_BIT   = 1;

  // reset values
  localparam logic [7:0]  PMT_RST_COUNT   = 8'h00;
  localparam logic [7:0]  PMT_RST_PERIOD  = 8'hFF;
  localparam logic [6:0]  PMT_RST_CONTROL = 7'h00;
  localparam logic [7:0]  PMT_CTRL_MASK   = 8'h7F;

  // prescaler terminal counts (divide minus one)
  localparam logic [3:0]  PMT_PRE_DIV1    = 4'h0;
  localparam logic [3:0]  PMT_PRE_DIV4    = 4'h3;
  localparam logic [3:0]  PMT_PRE_DIV16   = 4'hF;

  // apb transfer phase of the slave, one-hot encoded
  typedef enum logic [2:0] {
    PMT_IDLE   = 3'b001,
    PMT_SETUP  = 3'b010,
    PMT_ACCESS = 3'b100
  } pmt_phase_e;

  // control register fields
  typedef struct packed {
    logic [3:0] postSel;
    logic       runBit;
    logic [1:0] preSel;
  } pmt_ctrl_s;

  // time-base outputs grouped for the serial port and pwm unit
  typedef struct packed {
    logic       matchPulse;
    logic       wrapPulse;
    logic [7:0] count;
    logic [7:0] period;
  } pmt_tbase_s;

endpackage : pmt_pkg

// >>> design/pmt_prescaler.sv
// prescaler: divides the instruction clock into counting ticks
module pmt_prescaler
  import pmt_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic [1:0] preSel,
  input  wire logic       runBit,
  input  wire logic       clearScalers,
  output logic            tick
);

  typedef struct packed {
    logic [3:0] cnt;
  } pmt_pre_state_s;

  pmt_pre_state_s state_reg;
  pmt_pre_state_s state_next;
  logic [3:0]     terminal;

  // 00 divides by one, 01 by four, 1x by sixteen
  always_comb begin
    if (preSel[1]) begin
      terminal = PMT_PRE_DIV16;
    end else if (preSel[0]) begin
      terminal = PMT_PRE_DIV4;
    end else begin
      terminal = PMT_PRE_DIV1;
    end
  end

  // counter holds while stopped, restarts from zero on a clear
  always_comb begin
    state_next = state_reg;
    tick       = 1'b0;
    if (clearScalers) begin
      state_next.cnt = 4'h0;
    end else if (runBit) begin
      if (state_reg.cnt >= terminal) begin
        state_next.cnt = 4'h0;
        tick           = 1'b1;
      end else begin
        state_next.cnt = state_reg.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : pmt_prescaler

// >>> design/pmt_postscaler.sv
// postscaler: passes one in N period matches on to the flag
module pmt_postscaler
  import pmt_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic [3:0] postSel,
  input  wire logic       match,
  input  wire logic       clearScalers,
  output logic            fire
);

  typedef struct packed {
    logic [3:0] cnt;
  } pmt_post_state_s;

  pmt_post_state_s state_reg;
  pmt_post_state_s state_next;

  // ratio is postSel plus one; match only arrives while running
  always_comb begin
    state_next = state_reg;
    fire       = 1'b0;
    if (clearScalers) begin
      state_next.cnt = 4'h0;
    end else if (match) begin
      if (state_reg.cnt >= postSel) begin
        state_next.cnt = 4'h0;
        fire           = 1'b1;
      end else begin
        state_next.cnt = state_reg.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : pmt_postscaler

// >>> design/pmt_timer.sv
// top: 8-bit period match timer with apb register slave and interrupt
module pmt_timer
  import pmt_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output pmt_tbase_s       timeBase
);

  // whole module state in one struct
  typedef struct packed {
    pmt_phase_e  phase;
    logic [7:0]  count;
    logic [7:0]  period;
    pmt_ctrl_s   ctrl;
    logic        matchFlag;
    logic        matchIrqEn;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    logic        irq;
    pmt_tbase_s  tbase;
  } pmt_state_s;

  pmt_state_s state_reg;
  pmt_state_s state_next;

  logic       tick;
  logic       periodMatch;
  logic       postFire;
  logic       clearScalers;
  logic       wrCount;
  logic       wrCtrl;
  logic       wrFlags;
  logic       wrEnables;
  logic       wrPeriod;
  logic       accessDone;
  logic       mapped;

  // decode a word index from a byte address; misaligned gives no match
  function automatic logic hit(input logic [11:0] addr,
                               input logic [7:0]  idx);
    hit = (addr[1:0] == 2'b00) && (addr[9:2] == idx) && !addr[11] &&
          !addr[10];
  endfunction : hit

  // register write strobes fire at the access edge, lane 0 must be on
  assign accessDone = psel && penable && state_reg.ready;
  assign mapped     = hit(paddr, PMT_IDX_FLAGS) ||
                      hit(paddr, PMT_IDX_COUNT) ||
                      hit(paddr, PMT_IDX_CONTROL) ||
                      hit(paddr, PMT_IDX_ENABLES) ||
                      hit(paddr, PMT_IDX_PERIOD);
  assign wrCount    = accessDone && pwrite && pstrb[0] &&
                      hit(paddr, PMT_IDX_COUNT);
  assign wrCtrl     = accessDone && pwrite && pstrb[0] &&
                      hit(paddr, PMT_IDX_CONTROL);
  assign wrFlags    = accessDone && pwrite && pstrb[0] &&
                      hit(paddr, PMT_IDX_FLAGS);
  assign wrEnables  = accessDone && pwrite && pstrb[0] &&
                      hit(paddr, PMT_IDX_ENABLES);
  assign wrPeriod   = accessDone && pwrite && pstrb[0] &&
                      hit(paddr, PMT_IDX_PERIOD);

  // scaler counters restart on count or control writes
  assign clearScalers = wrCount || wrCtrl;

  // match is seen on the tick that would advance past the period
  assign periodMatch = tick && (state_reg.count == state_reg.period);

  pmt_prescaler u_pre (
    .sys_clk      (sys_clk),
    .resetn       (resetn),
    .preSel       (state_reg.ctrl.preSel),
    .runBit       (state_reg.ctrl.runBit),
    .clearScalers (clearScalers),
    .tick         (tick)
  );

  pmt_postscaler u_post (
    .sys_clk      (sys_clk),
    .resetn       (resetn),
    .postSel      (state_reg.ctrl.postSel),
    .match        (periodMatch),
    .clearScalers (clearScalers),
    .fire         (postFire)
  );

  // next-state logic: apb phases, counter, flag, interrupt, outputs
  always_comb begin
    state_next             = state_reg;
    state_next.tbase.matchPulse = 1'b0;
    state_next.tbase.wrapPulse  = 1'b0;

    // apb slave answers with one wait state: ready rises in access
    case (state_reg.phase)
      PMT_IDLE: begin
        state_next.ready  = 1'b0;
        state_next.slverr = 1'b0;
        if (psel && !penable) begin
          state_next.phase = PMT_SETUP;
        end
      end
      PMT_SETUP: begin
        state_next.phase  = PMT_ACCESS;
        state_next.ready  = 1'b1;
        state_next.slverr = !mapped;
        state_next.rdata  = 32'h0000_0000;
        if (!pwrite) begin
          if (hit(paddr, PMT_IDX_FLAGS)) begin
            state_next.rdata[PMT_MATCH_BIT] = state_reg.matchFlag;
          end
          if (hit(paddr, PMT_IDX_ENABLES)) begin
            state_next.rdata[PMT_MATCH_BIT] = state_reg.matchIrqEn;
          end
          if (hit(paddr, PMT_IDX_COUNT)) begin
            state_next.rdata[7:0] = state_reg.count;
          end
          if (hit(paddr, PMT_IDX_CONTROL)) begin
            state_next.rdata[6:0] = state_reg.ctrl;
          end
          if (hit(paddr, PMT_IDX_PERIOD)) begin
            state_next.rdata[7:0] = state_reg.period;
          end
        end
      end
      PMT_ACCESS: begin
        state_next.phase  = PMT_IDLE;
        state_next.ready  = 1'b0;
        state_next.slverr = 1'b0;
      end
      default: begin
        state_next.phase = PMT_IDLE;
        state_next.ready = 1'b0;
      end
    endcase

    // counting: a software write wins over the tick in the same cycle
    if (wrCount) begin
      state_next.count = pwdata[7:0];
    end else if (tick) begin
      if (periodMatch) begin
        state_next.count = 8'h00;
        state_next.tbase.matchPulse = 1'b1;
        state_next.tbase.wrapPulse  = 1'b1;
      end else begin
        state_next.count = state_reg.count + 8'h01;
      end
    end

    // control write sets only control and restarts the scalers, not the count
    if (wrCtrl) begin
      state_next.ctrl = pwdata[6:0];
    end
    if (wrPeriod) begin
      state_next.period = pwdata[7:0];
    end
    if (wrEnables) begin
      state_next.matchIrqEn = pwdata[PMT_MATCH_BIT];
    end

    // sticky flag: writing one clears it, a new event in that cycle wins
    if (wrFlags && pwdata[PMT_MATCH_BIT]) begin
      state_next.matchFlag = 1'b0;
    end
    if (postFire) begin
      state_next.matchFlag = 1'b1;
    end

    // level irq computed from next values so it tracks with no extra lag
    state_next.irq = state_next.matchFlag && state_next.matchIrqEn;

    state_next.tbase.count  = state_next.count;
    state_next.tbase.period = state_next.period;
  end

  // single register bank; async reset loads constants only
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg              <= '0;
      state_reg.phase        <= PMT_IDLE;
      state_reg.count        <= PMT_RST_COUNT;
      state_reg.period       <= PMT_RST_PERIOD;
      state_reg.ctrl         <= PMT_RST_CONTROL;
      state_reg.tbase.period <= PMT_RST_PERIOD;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata   = state_reg.rdata;
  assign pready   = state_reg.ready;
  assign pslverr  = state_reg.slverr;
  assign irq      = state_reg.irq;
  assign timeBase = state_reg.tbase;

endmodule : pmt_timer

// >>> sim/pmt_timer_sva.sv
// checker: port-level timing relations of the period match timer
module pmt_timer_sva
  import pmt_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire pmt_tbase_s  timeBase
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // a write access in progress; registered mirrors may lag it by one cycle
  logic wrAcc;
  assign wrAcc = psel && penable && pwrite;

  // setup, then exactly one wait cycle before the answer
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    !pready ##1 pready;
  endsequence

  chk_ready_wait: assert property (s_setup |=> s_answer)
    else $error("apb answer not after one wait cycle");
  chk_wrap_zero: assert property (timeBase.wrapPulse |->
    timeBase.count == 8'h00) else $error("wrap without zero count");
  chk_match_wrap: assert property (timeBase.matchPulse |=>
    !timeBase.matchPulse || $past(timeBase.period) == 8'h00)
    else $error("match repeated with nonzero period");
  chk_match_prev: assert property (timeBase.matchPulse |->
    $past(timeBase.count) == $past(timeBase.period))
    else $error("match but count was not at period");
  chk_count_step: assert property ($changed(timeBase.count) |->
    timeBase.count == $past(timeBase.count) + 8'h01 ||
    timeBase.count == 8'h00 || $past(wrAcc) || $past(wrAcc, 2))
    else $error("count moved other than by one");
  chk_period_hold: assert property ($changed(timeBase.period) |->
    $past(wrAcc) || $past(wrAcc, 2)) else $error("period changed alone");
  chk_rdata_high: assert property (pready |->
    prdata[31:8] == 24'h000000) else $error("read data upper bits set");
  chk_irq_fall: assert property ($fell(irq) |->
    $past(wrAcc) || $past(wrAcc, 2)) else $error("irq dropped alone");
endmodule : pmt_timer_sva

bind pmt_timer pmt_timer_sva u_pmt_timer_sva (
  .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
  .timeBase(timeBase)
);

// >>> sim/pmt_timer_tb.sv
// bench: register-level tests of the period match timer
module pmt_timer_tb
  import pmt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        sys_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [3:0]  pstrb   = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  pmt_tbase_s  timeBase;
  int          failures = 0;
  int          n_checks = 0;
  logic [7:0]  q;
  logic        e;
  logic [7:0]  ri [5] = '{PMT_IDX_FLAGS, PMT_IDX_COUNT, PMT_IDX_CONTROL,
                          PMT_IDX_ENABLES, PMT_IDX_PERIOD};
  logic [7:0]  rv [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF};
  logic [3:0]  ps [4] = '{4'h0, 4'h1, 4'h7, 4'hF};
  int          dv [4] = '{1, 4, 16, 16};

  always #10 sys_clk = ~sys_clk;

  pmt_timer u_pmt_timer (
    .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .timeBase(timeBase)
  );

  task automatic chk(string nm, logic [7:0] ex, logic [7:0] got);
    n_checks++;
    if (got !== ex) begin
      failures++;
      $display("ERROR %s exp %h got %h", nm, ex, got);
    end
  endtask : chk

  task automatic chkn(string nm, int ex, int got);
    n_checks++;
    if (got != ex) begin
      failures++;
      $display("ERROR %s exp %0d got %0d", nm, ex, got);
    end
  endtask : chkn

  // one apb transfer; an edge passes first so psel is never set twice
  task automatic xfer(logic w, logic [7:0] i, logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge sys_clk);
    end
    if (n >= 20) failures++;
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(logic [7:0] i, logic [7:0] d);
    xfer(1'b1, i, d);
  endtask : wr

  task automatic rd(string nm, logic [7:0] i, logic [7:0] ex);
    xfer(1'b0, i, 8'h00);
    chk(nm, ex, q);
  endtask : rd

  // spacing in cycles between two consecutive match pulses
  task automatic gap(string nm, int ex);
    int n;
    n = 0;
    while (timeBase.matchPulse !== 1'b1 && n < 300) begin
      n++;
      @(posedge sys_clk);
    end
    n = 0;
    @(posedge sys_clk);
    while (timeBase.matchPulse !== 1'b1 && n < 300) begin
      n++;
      @(posedge sys_clk);
    end
    chkn(nm, ex, n + 1);
  endtask : gap

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    failures++;
    tally_and_finish();
  end

  initial begin
    int n;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    foreach (ri[k]) rd("reset", ri[k], rv[k]);
    xfer(1'b0, 8'h00, 8'h00);
    chk("unmapErr", 8'h01, {7'h0, e});
    wr(PMT_IDX_CONTROL, 8'hF8);
    rd("ctrlBit7", PMT_IDX_CONTROL, 8'h78);
    // stopped: count must hold across control writes and idle time
    wr(PMT_IDX_CONTROL, 8'h03);
    wr(PMT_IDX_COUNT, 8'h42);
    wr(PMT_IDX_CONTROL, 8'h7B);
    repeat (40) @(posedge sys_clk);
    rd("countHeld", PMT_IDX_COUNT, 8'h42);
    wr(PMT_IDX_PERIOD, 8'h03);
    rd("period", PMT_IDX_PERIOD, 8'h03);
    chk("tbPeriod", 8'h03, timeBase.period);
    // a write with the lane 0 strobe off is answered but must not land
    pstrb <= 4'hE;
    wr(PMT_IDX_PERIOD, 8'h55);
    pstrb <= 4'hF;
    rd("laneOff", PMT_IDX_PERIOD, 8'h03);
    // every prescale code: spacing is (period plus one) times divide
    for (int k = 0; k < 4; k++) begin
      wr(PMT_IDX_COUNT, 8'h00);
      wr(PMT_IDX_CONTROL, 8'h04 | 8'(k));
      gap("spacing", 4 * dv[k]);
    end
    wr(PMT_IDX_PERIOD, 8'h01);
    wr(PMT_IDX_ENABLES, 8'h02);
    // postscale: matches counted from a control write until irq rises
    foreach (ps[k]) begin
      wr(PMT_IDX_CONTROL, 8'h00);
      wr(PMT_IDX_COUNT, 8'h00);
      wr(PMT_IDX_FLAGS, 8'h02);
      rd("flagClr", PMT_IDX_FLAGS, 8'h00);
      wr(PMT_IDX_CONTROL, {1'b0, ps[k], 3'b100});
      n = 0;
      for (int t = 0; t < 200 && irq !== 1'b1; t++) begin
        @(posedge sys_clk);
        if (timeBase.matchPulse === 1'b1) n++;
      end
      chkn("postCount", int'(ps[k]) + 1, n);
      rd("flagSet", PMT_IDX_FLAGS, 8'h02);
    end
    wr(PMT_IDX_ENABLES, 8'h00);
    rd("enables", PMT_IDX_ENABLES, 8'h00);
    chk("irqMasked", 8'h00, {7'h0, irq});
    tally_and_finish();
  end
endmodule : pmt_timer_tb
